// >>> rtl/opis_defs.svh
`ifndef OPIS_DEFS_SVH
`define OPIS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define OPIS_REG_LOWER_WORD 8'h00
`define OPIS_REG_UPPER_WORD 8'h01
`define OPIS_REG_PULL_RANGE 8'h02
`define OPIS_UPPER_OE_BIT 10
`define OPIS_UPPER_MASK 16'h07ff
`define OPIS_PULL_MASK 16'h000f
`define OPIS_PULL_DEFAULT 4'h6
`define OPIS_ADDR_PIN_LOW 7'h62
`define OPIS_ADDR_PIN_HIGH 7'h6a
`define OPIS_ADDR_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OPIS_CLK_HZ 10000000
`define OPIS_START_DELAY_US 103
`define OPIS_START_DELAY_CYC ((`OPIS_START_DELAY_US * `OPIS_CLK_HZ) / 1000000)
`define OPIS_SETTLE_NS 16500
`define OPIS_SETTLE_CYC ((`OPIS_SETTLE_NS * (`OPIS_CLK_HZ / 1000000)) / 1000)
`define OPIS_HOST_DIV 8'h32

`endif

// >>> rtl/opis_pkg.sv
package opis_pkg;
	typedef enum logic [5:0] {
		OPIS_IDLE = 6'h01,
		OPIS_ADDR = 6'h02,
		OPIS_ACK = 6'h04,
		OPIS_RX = 6'h08,
		OPIS_TX = 6'h10,
		OPIS_MACK = 6'h20
	} opis_state_t;

	typedef enum logic [6:0] {
		OPIS_H_IDLE = 7'h01,
		OPIS_H_START = 7'h02,
		OPIS_H_BIT = 7'h04,
		OPIS_H_STOP = 7'h08,
		OPIS_H_DONE = 7'h10,
		OPIS_H_RSTART = 7'h20,
		OPIS_H_GAP = 7'h40
	} opis_hstate_t;
endpackage

// >>> rtl/opis_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface opis_bus_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// Open-drain wired-and with pull-ups: idle lines read high.
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_m_o,
		output sda_m_oe);
endinterface
`default_nettype wire

// >>> rtl/opis_device.sv
// Behaviour
// [R1] Pull-range bits 15:4 read zero, ignore writes.
// [R2] Pull-range field decodes sixteen ranges, 6.25-3200 ppm.
// [R3] Pull field loads factory value, software may overwrite.
// [R4] Slave only; bus at most 1 Mbit/s.
// [R5] SDA changes only while SCL low.
// [R6] START/STOP detected as SDA edges, SCL high.
// [R7] Repeated START begins a new transfer.
// [R8] Bytes are eight bits, MSB first, unlimited count.
// [R9] Ninth clock carries acknowledge, low means ACK.
// [R10] NACK only on device address mismatch.
// [R11] Read: release on master ACK, continue on NACK.
// [R12] Seven-bit address plus read/write bit.
// [R13] Register address byte follows device address.
// [R14] Register address increments per word, wraps.
// [R15] Words are sixteen bits, high byte first.
// [R16] Read without address uses current pointer, resets zero.
// [R17] Master writes start address before reads.
// [R18] Master makes all START/STOP, handles NACK.
// [R19] Pull starts within 140 us of upper word.
// [R20] Pull settles within 20 us.
// [R21] 26-bit control word applied on upper load.
// [R22] Upper bit 10 enables output unless pin controlled.
// [R23] Pin-select address 1100010 or 1101010.
// [R24] Register write commits only after full word.
`timescale 1ns/1ps
`default_nettype none
`include "opis_defs.svh"
module opis_device #(
	parameter logic [3:0] PULL_FACTORY = `OPIS_PULL_DEFAULT,
	parameter int START_DELAY_CYC = `OPIS_START_DELAY_CYC,
	parameter int SETTLE_CYC = `OPIS_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	opis_bus_if.device bus,
	input wire logic address_select_pin_i,
	input wire logic oe_pin_mode_i,
	output logic [25:0] control_word_o,
	output logic [3:0] pull_range_o,
	output logic output_enable_o,
	output logic pull_active_o,
	output logic pull_settled_o
);
	// ------------------------------------------------------------------------
	// Pin synchronisers and condition detection
	// ------------------------------------------------------------------------
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic scl_prev_reg, sda_prev_reg;
	logic [1:0] sel_sync_reg, oe_mode_sync_reg;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			sel_sync_reg <= 2'h0;
			oe_mode_sync_reg <= 2'h0;
		end else if (ce_i) begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
			sel_sync_reg <= {sel_sync_reg[0], address_select_pin_i};
			oe_mode_sync_reg <= {oe_mode_sync_reg[0], oe_pin_mode_i};
		end
	end
	wire scl_s = scl_sync_reg[1];
	wire sda_s = sda_sync_reg[1];
	wire scl_rise = scl_s && !scl_prev_reg;
	wire scl_fall = !scl_s && scl_prev_reg;
	wire start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s; // [R6] [R7]
	wire stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s; // [R6]

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	opis_pkg::opis_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, ptr_reg, tx_reg;
	logic byte_idx_reg, addr_phase_reg, rw_reg, ptr_byte_reg, nack_reg, sda_drive_reg;
	logic [7:0] hi_byte_reg;
	logic [15:0] lower_reg;
	logic [10:0] upper_reg;
	logic [3:0] pull_reg;

	wire [6:0] own_addr = sel_sync_reg[1] ? `OPIS_ADDR_PIN_HIGH : `OPIS_ADDR_PIN_LOW; // [R23]
	wire addr_match = shift_reg[7:1] == own_addr; // [R12]
	wire [15:0] rd_word = (ptr_reg == `OPIS_REG_LOWER_WORD) ? lower_reg :
		(ptr_reg == `OPIS_REG_UPPER_WORD) ? {5'h00, upper_reg} :
		(ptr_reg == `OPIS_REG_PULL_RANGE) ? {12'h000, pull_reg} : 16'h0000; // [R1]
	wire [7:0] rd_byte = byte_idx_reg ? rd_word[7:0] : rd_word[15:8]; // [R15]
	wire [15:0] wr_word = {hi_byte_reg, shift_reg};
	wire word_done = (state_reg == opis_pkg::OPIS_ACK) && scl_fall && !addr_phase_reg
		&& byte_idx_reg;
	wire wr_commit = word_done && !rw_reg && !nack_reg; // [R24]
	wire upper_load = wr_commit && ptr_reg == `OPIS_REG_UPPER_WORD;

	// ------------------------------------------------------------------------
	// Bit-level state machine
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= opis_pkg::OPIS_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= `OPIS_ADDR_RESET; // [R16]
			byte_idx_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			rw_reg <= 1'b0;
			ptr_byte_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_drive_reg <= 1'b0;
			hi_byte_reg <= 8'h00;
		end else if (ce_i) begin
			if (start_det) begin // [R7]
				state_reg <= opis_pkg::OPIS_ADDR;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= 1'b0; // [R24]
				ptr_byte_reg <= 1'b0;
				sda_drive_reg <= 1'b0;
			end else if (stop_det) begin
				state_reg <= opis_pkg::OPIS_IDLE;
				sda_drive_reg <= 1'b0;
			end else begin
				unique case (state_reg)
				opis_pkg::OPIS_IDLE: begin
				end
				opis_pkg::OPIS_ADDR, opis_pkg::OPIS_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s}; // [R8]
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						bit_cnt_reg <= 4'h0;
						if (state_reg == opis_pkg::OPIS_ADDR) begin
							nack_reg <= !addr_match; // [R10]
							rw_reg <= shift_reg[0];
							addr_phase_reg <= !shift_reg[0]; // [R13]
							sda_drive_reg <= addr_match; // [R9]
							shift_reg <= 8'h00;
						end else begin
							nack_reg <= 1'b0;
							sda_drive_reg <= 1'b1; // [R9] [R10]
							if (addr_phase_reg)
								ptr_byte_reg <= 1'b1; // [R13]
							else if (!byte_idx_reg)
								hi_byte_reg <= shift_reg;
						end
						state_reg <= opis_pkg::OPIS_ACK;
					end
				end
				opis_pkg::OPIS_ACK: begin
					if (scl_fall) begin
						sda_drive_reg <= 1'b0;
						if (nack_reg) begin
							state_reg <= opis_pkg::OPIS_IDLE; // [R18]
						end else if (rw_reg) begin
							tx_reg <= rd_byte;
							sda_drive_reg <= !rd_byte[7];
							state_reg <= opis_pkg::OPIS_TX;
						end else begin
							if (ptr_byte_reg) begin
								ptr_reg <= shift_reg; // [R13]
								addr_phase_reg <= 1'b0;
								byte_idx_reg <= 1'b0;
							end else if (!addr_phase_reg) begin
								byte_idx_reg <= !byte_idx_reg;
								if (byte_idx_reg)
									ptr_reg <= ptr_reg + 8'h01; // [R14]
							end
							state_reg <= opis_pkg::OPIS_RX;
						end
						ptr_byte_reg <= 1'b0;
					end
				end
				opis_pkg::OPIS_TX: begin
					if (scl_fall) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'h7) begin
							sda_drive_reg <= 1'b0; // [R9]
							bit_cnt_reg <= 4'h0;
							byte_idx_reg <= !byte_idx_reg;
							if (byte_idx_reg)
								ptr_reg <= ptr_reg + 8'h01; // [R14]
							state_reg <= opis_pkg::OPIS_MACK;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							sda_drive_reg <= !tx_reg[6]; // [R5] [R8]
						end
					end
				end
				opis_pkg::OPIS_MACK: begin
					if (scl_rise) begin
						nack_reg <= sda_s;
					end else if (scl_fall) begin
						// A master NACK keeps streaming; only ACK releases the line.
						if (nack_reg) begin // [R11]
							tx_reg <= rd_byte;
							sda_drive_reg <= !rd_byte[7];
							state_reg <= opis_pkg::OPIS_TX;
						end else begin
							state_reg <= opis_pkg::OPIS_IDLE; // [R11]
						end
						nack_reg <= 1'b0;
					end
				end
				default: state_reg <= opis_pkg::OPIS_IDLE;
				endcase
			end
		end
	end
	assign bus.sda_s_o = 1'b0;
	assign bus.sda_s_oe = sda_drive_reg; // [R4] [R5]

	// ------------------------------------------------------------------------
	// Register writes and frequency pull timing
	// ------------------------------------------------------------------------
	logic [15:0] delay_cnt_reg;
	logic [15:0] settle_cnt_reg;
	logic pending_reg;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lower_reg <= 16'h0000;
			upper_reg <= 11'h000;
			pull_reg <= PULL_FACTORY; // [R3]
			control_word_o <= 26'h0000000;
			pending_reg <= 1'b0;
			delay_cnt_reg <= 16'h0000;
			settle_cnt_reg <= 16'h0000;
			pull_active_o <= 1'b0;
			pull_settled_o <= 1'b1;
		end else if (ce_i) begin
			if (wr_commit && ptr_reg == `OPIS_REG_LOWER_WORD)
				lower_reg <= wr_word;
			if (upper_load)
				upper_reg <= 11'(wr_word & `OPIS_UPPER_MASK);
			if (wr_commit && ptr_reg == `OPIS_REG_PULL_RANGE)
				pull_reg <= wr_word[3:0]; // [R1] [R3]
			if (upper_load) begin // [R19] [R21]
				pending_reg <= 1'b1;
				delay_cnt_reg <= 16'(START_DELAY_CYC);
				pull_settled_o <= 1'b0;
				pull_active_o <= 1'b0;
			end else if (pending_reg) begin
				if (delay_cnt_reg <= 16'h0001) begin
					pending_reg <= 1'b0;
					control_word_o <= {upper_reg[9:0], lower_reg}; // [R21]
					pull_active_o <= 1'b1;
					settle_cnt_reg <= 16'(SETTLE_CYC);
				end else begin
					delay_cnt_reg <= delay_cnt_reg - 16'h0001;
				end
			end else if (pull_active_o) begin // [R20]
				if (settle_cnt_reg <= 16'h0001) begin
					pull_active_o <= 1'b0;
					pull_settled_o <= 1'b1;
				end else begin
					settle_cnt_reg <= settle_cnt_reg - 16'h0001;
				end
			end
		end
	end
	assign pull_range_o = pull_reg; // [R2]
	assign output_enable_o = oe_mode_sync_reg[1] ? 1'b1 : upper_reg[`OPIS_UPPER_OE_BIT]; // [R22]
endmodule
`default_nettype wire

// >>> rtl/opis_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "opis_defs.svh"
module opis_host #(
	parameter logic [7:0] HALF_DIV = `OPIS_HOST_DIV
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	opis_bus_if.host bus,
	input wire logic req_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic nack_o,
	output logic [15:0] rdata_o
);
	// ------------------------------------------------------------------------
	// Sequencer: one word per request. Writes send address, reg, two bytes;
	// reads write the register address then repeat START to read.
	// ------------------------------------------------------------------------
	opis_pkg::opis_hstate_t st_reg;
	logic [7:0] div_reg;
	logic phase_reg;
	logic [3:0] bit_reg;
	logic [2:0] byte_reg;
	logic [8:0] sh_reg;
	logic scl_reg, sda_reg, rd_reg;
	logic [1:0] sda_sync_reg;
	logic [6:0] da_reg;
	logic [7:0] ra_reg;
	logic [15:0] wd_reg;
	wire tick = div_reg == 8'h00; // [R4]
	wire sda_s = sda_sync_reg[1];
	wire [2:0] last_byte = rd_reg ? 3'h4 : 3'h3;
	wire [8:0] next_sh = (byte_reg == 3'h0) ? {da_reg, 1'b0, 1'b1} :
		(byte_reg == 3'h1) ? {ra_reg, 1'b1} :
		(byte_reg == 3'h2 && rd_reg) ? {da_reg, 1'b1, 1'b1} :
		(byte_reg == 3'h2) ? {wd_reg[15:8], 1'b1} :
		(byte_reg == 3'h3 && !rd_reg) ? {wd_reg[7:0], 1'b1} :
		(byte_reg == 3'h3) ? 9'h1ff : 9'h1fe;
	// The slave streams on only after a refusal, so the high byte is refused and
	// the low byte acknowledged, which frees the data line for the STOP.

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sda_sync_reg <= 2'h3;
		end else if (ce_i) begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg <= opis_pkg::OPIS_H_IDLE;
			div_reg <= 8'h00;
			phase_reg <= 1'b0;
			bit_reg <= 4'h0;
			byte_reg <= 3'h0;
			sh_reg <= 9'h1ff;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			rd_reg <= 1'b0;
			da_reg <= 7'h00;
			ra_reg <= 8'h00;
			wd_reg <= 16'h0000;
			done_o <= 1'b0;
			nack_o <= 1'b0;
			rdata_o <= 16'h0000;
		end else if (ce_i) begin
			done_o <= 1'b0;
			div_reg <= tick ? HALF_DIV : div_reg - 8'h01;
			unique case (st_reg)
			opis_pkg::OPIS_H_IDLE: begin
				if (req_i) begin
					da_reg <= dev_addr_i;
					ra_reg <= reg_addr_i;
					wd_reg <= wdata_i;
					rd_reg <= rd_i; // [R17]
					nack_o <= 1'b0;
					byte_reg <= 3'h0;
					st_reg <= opis_pkg::OPIS_H_START;
				end
			end
			opis_pkg::OPIS_H_START, opis_pkg::OPIS_H_RSTART: if (tick) begin
				if (!scl_reg) begin
					sda_reg <= 1'b1;
					scl_reg <= 1'b1;
				end else if (sda_reg) begin
					sda_reg <= 1'b0; // [R6] [R18]
				end else begin
					scl_reg <= 1'b0;
					sh_reg <= next_sh;
					bit_reg <= 4'h0;
					phase_reg <= 1'b0;
					st_reg <= opis_pkg::OPIS_H_BIT;
				end
			end
			opis_pkg::OPIS_H_BIT: if (tick) begin
				if (!phase_reg) begin
					sda_reg <= sh_reg[8]; // [R5] [R8]
					phase_reg <= 1'b1;
				end else if (!scl_reg) begin
					scl_reg <= 1'b1;
				end else begin
					scl_reg <= 1'b0;
					phase_reg <= 1'b0;
					sh_reg <= {sh_reg[7:0], sda_s};
					bit_reg <= bit_reg + 4'h1;
					if (bit_reg == 4'h8) begin // [R9]
						if (sda_s && byte_reg < 3'h3) begin
							nack_o <= 1'b1;
							st_reg <= opis_pkg::OPIS_H_STOP; // [R18]
						end else if (byte_reg == last_byte) begin
							st_reg <= opis_pkg::OPIS_H_STOP;
						end else if (byte_reg == 3'h1 && rd_reg) begin
							byte_reg <= 3'h2;
							st_reg <= opis_pkg::OPIS_H_RSTART; // [R7]
						end else begin
							byte_reg <= byte_reg + 3'h1;
							sh_reg <= next_sh;
							bit_reg <= 4'h0;
							st_reg <= opis_pkg::OPIS_H_GAP;
						end
						if (rd_reg && byte_reg == 3'h3)
							rdata_o[15:8] <= sh_reg[7:0]; // [R15]
						if (rd_reg && byte_reg == 3'h4)
							rdata_o[7:0] <= sh_reg[7:0];
					end
				end
			end
			opis_pkg::OPIS_H_GAP: begin
				sh_reg <= next_sh;
				st_reg <= opis_pkg::OPIS_H_BIT;
			end
			opis_pkg::OPIS_H_STOP: if (tick) begin
				if (!phase_reg) begin
					sda_reg <= 1'b0;
					phase_reg <= 1'b1;
				end else if (!scl_reg) begin
					scl_reg <= 1'b1;
				end else begin
					sda_reg <= 1'b1; // [R6]
					st_reg <= opis_pkg::OPIS_H_DONE;
				end
			end
			opis_pkg::OPIS_H_DONE: begin
				done_o <= 1'b1;
				phase_reg <= 1'b0;
				st_reg <= opis_pkg::OPIS_H_IDLE;
			end
			default: st_reg <= opis_pkg::OPIS_H_IDLE;
			endcase
		end
	end
	assign busy_o = st_reg != opis_pkg::OPIS_H_IDLE;
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = !scl_reg;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = !sda_reg;
endmodule
`default_nettype wire

// >>> test/opis_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "opis_defs.svh"
module opis_checker (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_s_oe_i,
	input wire logic sda_m_oe_i
);
	wire logic scl = scl_i;
	wire logic sda = sda_i;
	wire logic sda_s_oe = sda_s_oe_i;
	wire logic sda_m_oe = sda_m_oe_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ----
	// Frame tracking
	// ----
	logic scl_reg;
	logic sda_reg;
	logic rw_reg;
	logic dev_on_reg;
	logic muted_reg;
	logic [3:0] bits_reg;
	logic [2:0] bytes_reg;
	logic [7:0] shift_reg;
	wire logic rise = scl && !scl_reg;
	wire logic start = scl && scl_reg && sda_reg && !sda;
	wire logic stop = scl && scl_reg && !sda_reg && sda;
	wire logic ack_rise = rise && (bits_reg == 4'h8);
	wire logic foreign = shift_reg[7:1] != `OPIS_ADDR_PIN_LOW && shift_reg[7:1] != `OPIS_ADDR_PIN_HIGH;

	// Byte count saturates; only the first few bytes of a frame need telling apart.
	always_ff @(posedge clk_i) begin
		scl_reg <= scl;
		sda_reg <= sda;
		if (srst_i || start) begin
			bits_reg <= 4'h0;
			bytes_reg <= 3'h0;
			muted_reg <= 1'b0;
			dev_on_reg <= 1'b0;
			rw_reg <= 1'b0;
		end else if (rise) begin
			bits_reg <= ack_rise ? 4'h0 : bits_reg + 4'h1;
			shift_reg <= {shift_reg[6:0], sda};
			if (ack_rise && bytes_reg != 3'h7) begin
				bytes_reg <= bytes_reg + 3'h1;
			end
			if (ack_rise && bytes_reg == 3'h0) begin
				rw_reg <= shift_reg[0];
				dev_on_reg <= sda_s_oe;
				muted_reg <= !sda_s_oe;
			end
		end
	end

	a_dev_sda_stable: assert property (scl && scl_reg |-> $stable(sda_s_oe))
		else $error("device data moved while clock high");
	a_stop_releases: assert property (stop |-> ##1 !sda_s_oe [*4])
		else $error("device drove data after stop");
	a_foreign_nack: assert property (ack_rise && bytes_reg == 3'h0 && foreign |-> !sda_s_oe)
		else $error("device answered a foreign address");
	a_write_acked: assert property (ack_rise && bytes_reg != 3'h0 && dev_on_reg && !rw_reg
		|-> sda_s_oe)
		else $error("device left a written byte unanswered");
	a_read_releases: assert property (ack_rise && bytes_reg != 3'h0 && rw_reg |-> !sda_s_oe)
		else $error("device held data in master answer slot");
	a_mismatch_silent: assert property (muted_reg |-> !sda_s_oe)
		else $error("device drove data after refusing address");
	a_host_frames: assert property (start |-> sda_m_oe && !sda_s_oe)
		else $error("frame start not made by master");
	a_scl_high_time: assert property (rise |-> scl [*5])
		else $error("clock high phase shorter than rate limit");

	c_write_word: cover property (ack_rise && bytes_reg == 3'h3 && !rw_reg && dev_on_reg);
	c_read_word: cover property (ack_rise && bytes_reg == 3'h2 && rw_reg);
	c_refused: cover property (muted_reg && rise);
endmodule
`default_nettype wire

// >>> test/oscillator_pull_i2c_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module oscillator_pull_i2c_slave_test;
	localparam int START_CYC = 150;
	localparam int SETTLE_CYC = 5;
	logic clk_i;
	logic srst_i;
	logic req_i;
	logic rd_i;
	logic pin_i;
	logic oe_mode_i;
	logic [6:0] dev_addr_i;
	logic [7:0] reg_addr_i;
	logic [15:0] wdata_i;
	logic [15:0] rdata_o;
	logic [25:0] control_word_o;
	logic [3:0] pull_range_o;
	logic busy_o;
	logic done_o;
	logic nack_o;
	logic pull_active_o;
	logic pull_settled_o;
	logic output_enable_o;
	int mismatches = 0;
	int samples_checked = 0;
	wire logic [3:0] flags = {pull_settled_o, pull_active_o, done_o, busy_o};

	// ----
	// Both ends on one bus
	// ----
	opis_bus_if u_opis_bus_if();
	opis_device #(.START_DELAY_CYC(START_CYC), .SETTLE_CYC(SETTLE_CYC)) u_opis_device (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .bus(u_opis_bus_if),
		.address_select_pin_i(pin_i), .oe_pin_mode_i(oe_mode_i),
		.control_word_o(control_word_o), .pull_range_o(pull_range_o),
		.output_enable_o(output_enable_o), .pull_active_o(pull_active_o),
		.pull_settled_o(pull_settled_o));
	// Ten clocks per tick and three ticks per bit keep the bus at a third of the rate limit for sampling margin.
	opis_host #(.HALF_DIV(8'h09)) u_opis_host (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .bus(u_opis_bus_if), .req_i(req_i),
		.dev_addr_i(dev_addr_i), .rd_i(rd_i), .reg_addr_i(reg_addr_i), .wdata_i(wdata_i),
		.busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
	opis_checker u_opis_checker (.clk_i(clk_i), .srst_i(srst_i), .scl_i(u_opis_bus_if.scl),
		.sda_i(u_opis_bus_if.sda), .sda_s_oe_i(u_opis_bus_if.sda_s_oe),
		.sda_m_oe_i(u_opis_bus_if.sda_m_oe));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----
	// Shared tasks
	// ----
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic restart();
		srst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic wait_flag(input int idx, input int lim, output int n);
		n = 0;
		while (flags[idx] !== 1'b1) begin
			if (n == lim) begin
				check("wait", 32'h0, 32'h1);
				stop_test();
			end
			@(posedge clk_i);
			n++;
		end
	endtask

	task automatic xfer(input logic [6:0] da, input logic rd, input logic [7:0] ra,
		input logic [15:0] wd);
		int n;
		req_i <= 1'b1;
		dev_addr_i <= da;
		rd_i <= rd;
		reg_addr_i <= ra;
		wdata_i <= wd;
		@(posedge clk_i);
		wait_flag(0, 4, n);
		req_i <= 1'b0;
		wait_flag(1, 3000, n);
		repeat (2) @(posedge clk_i);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		check("pull", pull_range_o, 32'h6);
		check("pointer", u_opis_device.ptr_reg, 32'h0);
		check("word", control_word_o, 32'h0);
		check("settled", pull_settled_o, 32'h1);
		check("oe", output_enable_o, 32'h0);
		xfer(7'h62, 1'b1, 8'h02, 16'h0);
		check("nack", nack_o, 32'h0);
		check("rdata", rdata_o, 32'h6);
		// The master's acknowledge on the low byte must leave the data line free.
		check("released", u_opis_bus_if.sda, 32'h1);
		restart();
		$display("test reset done");
	endtask

	task automatic t_codes();
		for (int k = 0; k < 16; k++) begin
			xfer(7'h62, 1'b0, 8'h02, {12'hfff, 4'(k)});
			check("code", pull_range_o, k);
		end
		xfer(7'h62, 1'b1, 8'h02, 16'h0);
		check("rdata", rdata_o, 32'hf);
		restart();
		$display("test codes done");
	endtask

	task automatic t_word();
		int n;
		xfer(7'h62, 1'b0, 8'h00, 16'hb234);
		check("lower only", control_word_o, 32'h0);
		xfer(7'h62, 1'b0, 8'h01, 16'hfffd);
		check("early", pull_active_o, 32'h0);
		wait_flag(2, START_CYC, n);
		check("word", control_word_o, 32'h3fdb234);
		repeat (SETTLE_CYC + 2) @(posedge clk_i);
		check("active", pull_active_o, 32'h0);
		check("settled", pull_settled_o, 32'h1);
		check("oe", output_enable_o, 32'h1);
		xfer(7'h62, 1'b1, 8'hff, 16'h0);
		check("unmapped", rdata_o, 32'h0);
		check("wrap", u_opis_device.ptr_reg, 32'h0);
		xfer(7'h62, 1'b1, 8'h01, 16'h0);
		check("upper", rdata_o, 32'h7fd);
		restart();
		oe_mode_i <= 1'b1;
		// The mode pin passes two synchroniser stages before it steers the output.
		repeat (3) @(posedge clk_i);
		check("pin oe", output_enable_o, 32'h1);
		oe_mode_i <= 1'b0;
		$display("test word done");
	endtask

	task automatic t_addr();
		pin_i <= 1'b1;
		xfer(7'h62, 1'b0, 8'h02, 16'h3);
		check("nack low", nack_o, 32'h1);
		check("kept", pull_range_o, 32'h6);
		xfer(7'h6a, 1'b0, 8'h02, 16'h9);
		check("ack high", nack_o, 32'h0);
		check("taken", pull_range_o, 32'h9);
		pin_i <= 1'b0;
		xfer(7'h6a, 1'b0, 8'h02, 16'h1);
		check("nack high", nack_o, 32'h1);
		check("kept", pull_range_o, 32'h9);
		$display("test address done");
	endtask

	initial begin
		srst_i = 1'b1;
		req_i = 1'b0;
		rd_i = 1'b0;
		pin_i = 1'b0;
		oe_mode_i = 1'b0;
		dev_addr_i = 7'h00;
		reg_addr_i = 8'h00;
		wdata_i = 16'h0000;
		restart();
		t_reset();
		t_codes();
		t_word();
		t_addr();
		stop_test();
	end
endmodule
`default_nettype wire
